// [hdl/beat_queue.sv]
`timescale 1ns/100ps
module beat_queue #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + push - pop);
    end
  end
endmodule

// [hdl/tx_hang_checker.sv]
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - No second first beat before last beat
// - No last beat without opened packet
// - Qualifier high with first or last beat
// - Length within advertised initial credit
// - Credit field covers requested credits
// - Flag ready low over 100 cycles
// - Expose transmit queue full status
// - Payload matches header length
// - Byte enables follow stream rules
// - Format and type combination valid
// - Digest bit demands trailing ECRC dword
// - 3DW memory request payload never crosses 4KB boundary
// - Memory write within max payload
// - Outstanding reads within completion credit
module tx_hang_checker
  import txmon_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Observed transmit stream
  input  wire logic        tx_packet_first_beat_i,
  input  wire logic        tx_packet_last_beat_i,
  input  wire logic        stream_beat_qualifier_i,
  input  wire logic [3:0]  tx_byte_en_i,
  input  wire logic [31:0] tx_data_i,
  input  wire logic        tx_accept_flag_i,
  input  wire credit_t     tx_credit_i,
  input  wire logic        transmit_queue_full_i,
  input  wire logic        cpl_returned_i,
  input  wire logic [9:0]  cpl_returned_len_i,
  // Captured beats out
  output logic             cap_valid_o,
  input  wire logic        cap_ready_i,
  output logic [31:0]      cap_data_o,
  output logic             cap_drop_o,
  // Status
  output logic             hang_o,
  output logic             queue_full_o,
  output logic             any_error_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic fmt_type_ok(input logic [1:0] f, input logic [4:0] t);
    logic ok;
    ok = 1'b0;
    if (t == TYPE_MEM) begin
      ok = 1'b1;
    end else if (t == TYPE_CPL || t == TYPE_CFG0) begin
      ok = (f == FMT_3DW_ND) || (f == FMT_3DW_D);
    end
    return ok;
  endfunction

  function automatic logic [11:0] dw_len(input logic [9:0] l);
    return (l == 10'h000) ? 12'h400 : {2'h0, l};
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [11:0]        init_fc;
  logic [11:0]        max_payload;
  logic [11:0]        cpl_alloc;
  logic [NUM_ERR-1:0] err;
  logic [NUM_ERR-1:0] next_err;
  logic [7:0]         low_cnt;
  logic               hang;
  pkt_state_t         pk_state;
  logic [1:0]         hdr_idx;
  logic [1:0]         fmt;
  logic [4:0]         ptype;
  logic               td;
  logic [11:0]        len_dw;
  logic [11:0]        data_cnt;
  logic [11:0]        outstanding;
  logic               ap_valid;
  logic               ap_write;
  logic [7:0]         ap_addr;
  logic               beat;
  logic [11:0]        expect_dw;
  logic               is_mwr;
  logic               is_mrd;
  logic [11:0]        hdr_len;

  assign beat = ce_i & stream_beat_qualifier_i & tx_accept_flag_i;

  // ****************************************
  // Packet framing
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pk_state <= PK_IDLE;
      hdr_idx  <= 2'h0;
      data_cnt <= 12'h000;
      fmt      <= FMT_3DW_ND;
      ptype    <= TYPE_MEM;
      td       <= 1'b0;
      len_dw   <= 12'h000;
    end else if (beat) begin
      if (tx_packet_first_beat_i) begin
        fmt      <= tx_data_i[HDR_FMT_LSB +: 2];
        ptype    <= tx_data_i[HDR_TYPE_LSB +: 5];
        td       <= tx_data_i[HDR_TD_BIT];
        len_dw   <= dw_len(tx_data_i[HDR_LEN_LSB +: 10]);
        hdr_idx  <= 2'h1;
        data_cnt <= 12'h000;
        pk_state <= tx_packet_last_beat_i ? PK_IDLE : PK_HDR;
      end else if (pk_state != PK_IDLE) begin
        if (pk_state == PK_HDR && hdr_idx != (fmt[0] ? 2'h3 : 2'h2)) begin
          hdr_idx <= 2'(hdr_idx + 1'b1);
        end else begin
          pk_state <= PK_BODY;
          data_cnt <= (pk_state == PK_BODY) ? 12'(data_cnt + 1'b1) : 12'h000;
        end
        if (tx_packet_last_beat_i) begin
          pk_state <= PK_IDLE;
        end
      end
    end
  end

  // Body dwords counted exclude every header beat
  assign expect_dw = 12'((fmt[1] ? len_dw : 12'h000) + {11'h000, td});
  // Decoded from the wires, so the opening beat judges its own packet
  assign hdr_len   = dw_len(tx_data_i[HDR_LEN_LSB +: 10]);
  assign is_mwr    = (tx_data_i[HDR_TYPE_LSB +: 5] == TYPE_MEM) && tx_data_i[HDR_FMT_LSB+1];
  assign is_mrd    = (tx_data_i[HDR_TYPE_LSB +: 5] == TYPE_MEM) && !tx_data_i[HDR_FMT_LSB+1];

  // ****************************************
  // Violation detection
  // ****************************************
  always_comb begin
    next_err = err;
    if (ce_i) begin
      if (tx_packet_first_beat_i && stream_beat_qualifier_i && pk_state != PK_IDLE) begin
        next_err[ERR_DUP_SOP] = 1'b1;
      end
      if (tx_packet_last_beat_i && stream_beat_qualifier_i && !tx_packet_first_beat_i
          && pk_state == PK_IDLE) begin
        next_err[ERR_ORPHAN_EOP] = 1'b1;
      end
      if ((tx_packet_first_beat_i || tx_packet_last_beat_i) && !stream_beat_qualifier_i) begin
        next_err[ERR_NO_VALID] = 1'b1;
      end
      if (beat && tx_packet_first_beat_i) begin
        if (tx_data_i[HDR_FMT_LSB+1] && hdr_len > init_fc) begin
          next_err[ERR_INITFC] = 1'b1;
        end
        if (tx_data_i[HDR_FMT_LSB+1] && hdr_len > tx_credit_i.posted_data) begin
          next_err[ERR_CREDIT] = 1'b1;
        end
        if (!fmt_type_ok(tx_data_i[HDR_FMT_LSB +: 2], tx_data_i[HDR_TYPE_LSB +: 5])) begin
          next_err[ERR_FMT_TYPE] = 1'b1;
        end
        if (is_mwr && hdr_len > max_payload) begin
          next_err[ERR_MPS] = 1'b1;
        end
        if (is_mrd && 13'(outstanding) + 13'(hdr_len) > 13'(cpl_alloc)) begin
          next_err[ERR_CPL_CRED] = 1'b1;
        end
      end
      // Address word is the third header dword for 3DW requests
      if (beat && pk_state == PK_HDR && hdr_idx == 2'h2 && ptype == TYPE_MEM && !fmt[0]
          && 13'(tx_data_i[11:0]) + 13'({len_dw, 2'b00}) > 13'(BOUNDARY_4K)) begin
        next_err[ERR_4K] = 1'b1;
      end
      if (beat && stream_beat_qualifier_i && tx_byte_en_i == 4'h0) begin
        next_err[ERR_BYTE_EN] = 1'b1;
      end
      if (beat && tx_packet_last_beat_i && pk_state == PK_BODY) begin
        if (12'(data_cnt + 1'b1) < expect_dw) begin
          next_err[td ? ERR_DIGEST : ERR_LENGTH] = 1'b1;
        end else if (12'(data_cnt + 1'b1) > expect_dw) begin
          next_err[ERR_LENGTH] = 1'b1;
        end
      end
      if (hang) begin
        next_err[ERR_HANG] = 1'b1;
      end
      if (transmit_queue_full_i) begin
        next_err[ERR_QFULL] = 1'b1;
      end
    end
  end

  // Sticky: only reset clears, so a set can never race a clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err <= '0;
    end else begin
      err <= next_err;
    end
  end

  // ****************************************
  // Hang monitor
  // ****************************************
  // Counter saturates so a long stall keeps hang high, stalls look alike
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_cnt <= 8'h00;
      hang    <= 1'b0;
    end else if (ce_i) begin
      if (tx_accept_flag_i) begin
        low_cnt <= 8'h00;
        hang    <= 1'b0;
      end else begin
        if (low_cnt != 8'hFF) begin
          low_cnt <= 8'(low_cnt + 1'b1);
        end
        hang <= (low_cnt >= HANG_LIMIT);
      end
    end
  end

  // ****************************************
  // Outstanding read tracking
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      outstanding <= 12'h000;
    end else if (ce_i) begin
      outstanding <= 12'(outstanding
        + ((beat && tx_packet_first_beat_i && is_mrd) ? hdr_len : 12'h000)
        - (cpl_returned_i ? dw_len(cpl_returned_len_i) : 12'h000));
    end
  end

  // ****************************************
  // Capture queue
  // ****************************************
  logic q_in_ready;
  beat_queue #(.WIDTH(QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH)) beat_queue_inst (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (beat),
    .in_ready_o  (q_in_ready),
    .in_data_i   (tx_data_i),
    .out_valid_o (cap_valid_o),
    .out_ready_i (cap_ready_i),
    .out_data_o  (cap_data_o)
  );
  // Observer cannot stall the core, so overflow is reported instead
  assign cap_drop_o = beat & ~q_in_ready;

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (ce_i && hready_i) begin
      ap_valid <= hsel_i & htrans_i[1];
      ap_write <= hwrite_i;
      ap_addr  <= haddr_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      init_fc     <= 12'hFFF;
      max_payload <= 12'h020;
      cpl_alloc   <= 12'hFFF;
    end else if (ce_i && ap_valid && ap_write) begin
      if (ap_addr == REG_LIMITS) begin
        init_fc     <= hwdata_i[11:0];
        max_payload <= hwdata_i[27:16];
      end else if (ap_addr == REG_CREDIT) begin
        cpl_alloc <= hwdata_i[11:0];
      end
    end
  end

  always_comb begin
    hrdata_o = 32'h0000_0000;
    unique case (ap_addr)
      REG_STATUS:  hrdata_o = {29'h0, any_error_o, queue_full_o, hang_o};
      REG_ERRORS:  hrdata_o = {18'h0, err};
      REG_LIMITS:  hrdata_o = {4'h0, max_payload, 4'h0, init_fc};
      REG_HANGCNT: hrdata_o = {24'h0, low_cnt};
      REG_CREDIT:  hrdata_o = {8'h0, outstanding, cpl_alloc};
      REG_FIFO:    hrdata_o = {30'h0, cap_valid_o, ~q_in_ready};
      default:     hrdata_o = 32'h0000_0000;
    endcase
  end

  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign hang_o       = hang;
  assign queue_full_o = transmit_queue_full_i;
  assign any_error_o  = |err;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_low_run;
    !tx_accept_flag_i && ce_i;
  endsequence

  chk_hang_after_limit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (low_cnt == HANG_LIMIT) and s_low_run |=> hang)
    else $error("hang not raised after limit");
  chk_hang_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && tx_accept_flag_i |=> !hang && low_cnt == 8'h00)
    else $error("hang not cleared on ready");
  chk_sticky_errors: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (err & $past(err)) == $past(err))
    else $error("error flag dropped");
  chk_dup_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && tx_packet_first_beat_i && stream_beat_qualifier_i && pk_state != PK_IDLE
    |=> err[ERR_DUP_SOP])
    else $error("duplicate first beat missed");
  chk_orphan_last: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && tx_packet_last_beat_i && stream_beat_qualifier_i && !tx_packet_first_beat_i
    && pk_state == PK_IDLE |=> err[ERR_ORPHAN_EOP])
    else $error("orphan last beat missed");
  chk_marker_qual: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && tx_packet_first_beat_i && !stream_beat_qualifier_i |=> err[ERR_NO_VALID])
    else $error("unqualified marker missed");
  chk_queue_full: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && transmit_queue_full_i |=> err[ERR_QFULL])
    else $error("queue full not recorded");
  chk_mps_limit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    beat && tx_packet_first_beat_i && is_mwr && hdr_len > max_payload
    |=> err[ERR_MPS])
    else $error("oversized write missed");
endmodule

// [hdl/txmon_pkg.sv]
package txmon_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_ERRORS   = 8'h04;
  localparam logic [7:0] REG_LIMITS   = 8'h08;
  localparam logic [7:0] REG_HANGCNT  = 8'h0C;
  localparam logic [7:0] REG_CREDIT   = 8'h10;
  localparam logic [7:0] REG_FIFO     = 8'h14;

  // ****************************************
  // Error flag positions
  // ****************************************
  localparam int ERR_DUP_SOP   = 0;
  localparam int ERR_ORPHAN_EOP = 1;
  localparam int ERR_NO_VALID  = 2;
  localparam int ERR_INITFC    = 3;
  localparam int ERR_CREDIT    = 4;
  localparam int ERR_HANG      = 5;
  localparam int ERR_QFULL     = 6;
  localparam int ERR_LENGTH    = 7;
  localparam int ERR_BYTE_EN   = 8;
  localparam int ERR_FMT_TYPE  = 9;
  localparam int ERR_DIGEST    = 10;
  localparam int ERR_4K        = 11;
  localparam int ERR_MPS       = 12;
  localparam int ERR_CPL_CRED  = 13;
  localparam int NUM_ERR       = 14;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          HANG_LIMIT_CYC = 100;
  localparam logic [7:0]  HANG_LIMIT     = 8'(HANG_LIMIT_CYC);

  // ****************************************
  // Header field positions (first dword)
  // ****************************************
  localparam int HDR_LEN_LSB  = 0;
  localparam int HDR_TD_BIT   = 15;
  localparam int HDR_TYPE_LSB = 24;
  localparam int HDR_FMT_LSB  = 29;
  localparam int BOUNDARY_4K  = 4096;

  localparam logic [1:0] FMT_3DW_ND = 2'h0;
  localparam logic [1:0] FMT_4DW_ND = 2'h1;
  localparam logic [1:0] FMT_3DW_D  = 2'h2;
  localparam logic [1:0] FMT_4DW_D  = 2'h3;
  localparam logic [4:0] TYPE_MEM   = 5'h00;
  localparam logic [4:0] TYPE_CPL   = 5'h0A;
  localparam logic [4:0] TYPE_CFG0  = 5'h04;

  localparam int QUEUE_DEPTH = 32;
  localparam int QUEUE_WIDTH = 32;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        first;
    logic        last;
    logic        qual;
    logic [3:0]  byte_en;
    logic [31:0] data;
  } beat_t;

  typedef struct packed {
    logic [11:0] posted_data;
    logic [11:0] cpl_data;
  } credit_t;

  typedef enum logic [1:0] {
    PK_IDLE = 2'b00,
    PK_HDR  = 2'b01,
    PK_BODY = 2'b10
  } pkt_state_t;

endpackage

// [test/core_model.sv]
`timescale 1ns/100ps
module core_model
  import txmon_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Bench controls
  input  wire logic [11:0] need_i,
  input  wire logic [11:0] give_i,
  input  wire logic        full_i,
  // Core side of the stream
  output logic             ready_o,
  output credit_t          credit_o,
  output logic             full_o
);
  // ****************************
  // Credits from the link partner
  // ****************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      credit_o <= '0;
    end else begin
      credit_o <= {give_i, give_i};
    end
  end
  // Starved credits hold ready low, which is how a real link hangs
  always_ff @(posedge clk_i) begin
    ready_o <= !sys_rst_i && (credit_o.posted_data >= need_i);
  end
  assign full_o = full_i;
endmodule

// [test/pcie_tx_stream_hang_checker_test.sv]
`timescale 1ns/100ps
module pcie_tx_stream_hang_checker_test
  import txmon_pkg::*;
;
  // ****************************
  // Signals
  // ****************************
  logic        clk_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic        hsel, hwrite, hready, hresp, first, last, qual, cpl;
  logic        cap_ready, cap_valid, cap_drop, hang, qfull, anyerr;
  logic        accept, core_full, full_in, ce, td_bit;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  be;
  logic [9:0]  cpl_len;
  logic [11:0] need, give;
  logic [31:0] haddr, hwdata, hrdata, rdata, tdata, cap_data;
  credit_t     credit;
  int          failures = 0;
  int          num_checks = 0;
  int          drops = 0;
  logic [31:0] sent[$];

  tx_hang_checker tx_hang_checker_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .tx_packet_first_beat_i(first), .tx_packet_last_beat_i(last),
    .stream_beat_qualifier_i(qual), .tx_byte_en_i(be), .tx_data_i(tdata),
    .tx_accept_flag_i(accept), .tx_credit_i(credit),
    .transmit_queue_full_i(core_full), .cpl_returned_i(cpl),
    .cpl_returned_len_i(cpl_len), .cap_valid_o(cap_valid),
    .cap_ready_i(cap_ready), .cap_data_o(cap_data), .cap_drop_o(cap_drop),
    .hang_o(hang), .queue_full_o(qfull), .any_error_o(anyerr));

  core_model core_model_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .need_i(need), .give_i(give),
    .full_i(full_in), .ready_o(accept), .credit_o(credit), .full_o(core_full));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (cap_drop === 1'h1) drops++;
  end

  // ****************************
  // Compare and report
  // ****************************
  task chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_b(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************
  // Bus and stream drivers
  // ****************************
  task hwait;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hready !== 1'h1 && k < 50);
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hwait;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    rdata = hrdata;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(1'h0, a, 32'h0);
    chk_w(nm, e, rdata);
  endtask

  task err(input int b, input string nm);
    ahb(1'h0, REG_ERRORS, 32'h0);
    chk_b(nm, 1'h1, rdata[b]);
    chk_b("any_error", 1'h1, anyerr);
  endtask

  // Beat stays on the wires until the core takes it
  task beat(input logic f, l, q, input logic [3:0] b, input logic [31:0] d);
    int k;
    first <= f;
    last <= l;
    qual <= q;
    be <= b;
    tdata <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (q && accept !== 1'h1 && k < 300);
    if (q && accept === 1'h1) sent.push_back(d);
  endtask

  task idle;
    first <= 1'h0;
    last <= 1'h0;
    qual <= 1'h0;
    @(posedge clk_i);
  endtask

  task pkt(input logic [1:0] f, input logic [4:0] t, input int len,
           input logic [31:0] a, input int extra);
    int nd;
    nd = f[1] ? len + extra : 0;
    need <= 12'(len);
    beat(1'h1, 1'h0, 1'h1, 4'hF, {1'h0, f, t, 8'h00, td_bit, 5'h00, 10'(len)});
    beat(1'h0, 1'h0, 1'h1, 4'hF, 32'h000000FF);
    beat(1'h0, nd == 0, 1'h1, 4'hF, a);
    for (int i = 1; i <= nd; i++) beat(1'h0, i == nd, 1'h1, 4'hF, $urandom);
    idle;
  endtask

  task rst;
    sys_rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
  endtask

  // ****************************
  // Scenarios
  // ****************************
  initial begin
    int k;
    {hsel, hwrite, first, last, qual, cpl, cap_ready, full_in, td_bit} = '0;
    ce = 1'h1;
    {haddr, hwdata, tdata} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    be = 4'hF;
    cpl_len = 10'h000;
    need = 12'h000;
    give = 12'hFFF;
    void'($urandom(84));
    rst;
    rd(REG_LIMITS, 32'h00200FFF, "limits");
    rd(REG_CREDIT, 32'h00000FFF, "cpl_credit");
    rd(8'h20, 32'h0, "unmapped");
    chk_b("hresp", 1'h0, hresp);
    // Random legal packets overfill the capture queue
    for (int p = 0; p < 10; p++) pkt(FMT_3DW_D, TYPE_MEM, 1 + $urandom % 8,
                                      32'(($urandom % 16) * 4096), 0);
    rd(REG_ERRORS, 32'h0, "errors_clean");
    chk_b("any_error", 1'h0, anyerr);
    rd(REG_FIFO, 32'h3, "fifo_full");
    chk_w("drops", 32'(sent.size() - 32), 32'(drops));
    cap_ready <= 1'h1;
    repeat (32) begin
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (cap_valid !== 1'h1 && k < 20);
      chk_w("cap_data", sent.pop_front(), cap_data);
    end
    @(posedge clk_i);
    rd(REG_FIFO, 32'h0, "fifo_empty");
    sent.delete();
    // Framing faults, then a beat with all byte enables low
    rst;
    beat(1'h1, 1'h0, 1'h1, 4'hF, 32'h40000002);
    beat(1'h1, 1'h0, 1'h1, 4'hF, 32'h40000002);
    idle;
    err(ERR_DUP_SOP, "dup_first");
    rst;
    rd(REG_ERRORS, 32'h0, "errors_after_reset");
    beat(1'h0, 1'h1, 1'h1, 4'hF, 32'h12345678);
    idle;
    err(ERR_ORPHAN_EOP, "orphan_last");
    rst;
    beat(1'h1, 1'h0, 1'h0, 4'hF, 32'h40000001);
    idle;
    err(ERR_NO_VALID, "no_qualifier");
    rst;
    beat(1'h1, 1'h0, 1'h1, 4'h0, 32'h40000001);
    idle;
    err(ERR_BYTE_EN, "byte_en");
    // Malformed and oversized packets
    rst;
    pkt(FMT_3DW_D, TYPE_MEM, 2, 32'h00000100, 1);
    err(ERR_LENGTH, "length");
    rst;
    ahb(1'h1, REG_LIMITS, 32'h00010FFF);
    pkt(FMT_3DW_D, TYPE_MEM, 2, 32'h00000100, 0);
    err(ERR_MPS, "payload_limit");
    rst;
    ahb(1'h1, REG_LIMITS, 32'h00200001);
    pkt(FMT_3DW_D, TYPE_MEM, 2, 32'h00000100, 0);
    err(ERR_INITFC, "init_credit");
    rst;
    pkt(FMT_3DW_D, TYPE_MEM, 2, 32'h00000FFC, 0);
    err(ERR_4K, "boundary");
    // Digest bit set but no trailing dword, then a bad format and type pair
    rst;
    td_bit = 1'h1;
    pkt(FMT_3DW_D, TYPE_MEM, 2, 32'h00000100, 0);
    td_bit = 1'h0;
    err(ERR_DIGEST, "digest");
    pkt(FMT_4DW_ND, TYPE_CPL, 1, 32'h00000000, 0);
    err(ERR_FMT_TYPE, "fmt_type");
    // Core out of step with its partner accepts a beat beyond the credit
    rst;
    give <= 12'h001;
    need <= 12'h000;
    repeat (2) @(posedge clk_i);
    beat(1'h1, 1'h1, 1'h1, 4'hF, 32'h40000002);
    idle;
    give <= 12'hFFF;
    err(ERR_CREDIT, "credit");
    // Outstanding reads against completion space
    rst;
    pkt(FMT_3DW_ND, TYPE_MEM, 2, 32'h00000200, 0);
    rd(REG_CREDIT, 32'h00002FFF, "outstanding");
    cpl <= 1'h1;
    cpl_len <= 10'h002;
    @(posedge clk_i);
    cpl <= 1'h0;
    @(posedge clk_i);
    rd(REG_CREDIT, 32'h00000FFF, "returned");
    ahb(1'h1, REG_CREDIT, 32'h00000002);
    pkt(FMT_3DW_ND, TYPE_MEM, 4, 32'h00000200, 0);
    err(ERR_CPL_CRED, "cpl_overrun");
    // Queue full status
    rst;
    full_in <= 1'h1;
    @(posedge clk_i);
    @(posedge clk_i);
    chk_b("queue_full", 1'h1, qfull);
    ahb(1'h0, REG_STATUS, 32'h0);
    chk_b("status_qfull", 1'h1, rdata[1]);
    full_in <= 1'h0;
    // Credit starvation holds ready low
    rst;
    give <= 12'h000;
    need <= 12'h001;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (accept !== 1'h0 && k < 10);
    repeat (100) @(posedge clk_i);
    chk_b("hang_early", 1'h0, hang);
    repeat (3) @(posedge clk_i);
    chk_b("hang", 1'h1, hang);
    err(ERR_HANG, "hang_flag");
    give <= 12'hFFF;
    repeat (4) @(posedge clk_i);
    chk_b("hang_cleared", 1'h0, hang);
    // Clock enable low freezes the stall counter
    give <= 12'h000;
    ce <= 1'h0;
    repeat (150) @(posedge clk_i);
    chk_b("hang_frozen", 1'h0, hang);
    ce <= 1'h1;
    wrap_up;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    wrap_up;
  end
endmodule
